/* File: rtl/mas_activation_sync.sv */
/*
 Measurement activation and group sync sequencer with Avalon-MM registers.
 Assumes an external ranging engine, serial framer and one 20 MHz clock.
*/
// Chosen here: the register addresses and register access over Avalon-MM.
// Functional notes
// R1 - Within 1200 ms of power: indicator red, outputs at power-up states, then start.
// R2 - Outputs hold power-up values and no distance until first process completes.
// R3 - Mode is continuous, start-on-poll, master or slave; continuous by default.
// R4 - Continuous: start every interval; on completion update outputs, store distance.
// R5 - Continuous: poll returns stored distance without disturbing the cycle.
// R6 - Poll mode: start only on poll; on completion update, store, go idle.
// R7 - Poll mode: reply carries previous completed distance, not the triggered one.
// R8 - Poll during a running process: finish it, then run one more.
// R9 - Master repeats at phase count times measurement interval.
// R10 - Master sends only timing commands; no distance, no poll answers.
// R11 - Slave starts on master command, offset by its phase 1 to 5.
// R12 - Master phase count 1 to 5, default 2.
// R13 - One phase master and phase-1 slaves measure together.
// R14 - Other party never sets slave phase above master count; such slave idles.
// R15 - Missing commands: slave stops, flashes red/green, then no-sync outputs after delay.
// R16 - Commands resume: leave no-sync, stop flash, resume measuring and updates.
// R17 - Sync traffic and ordinary serial never share the bus.
// R18 - Master and slave still update outputs after each measurement.
// R19 - Group holds 2 to 32 sensors, one master, rest slaves.
// R20 - Apart from sync, serial is addressed Modbus slave traffic.
// R21 - Master ignores ordinary serial until group control or teach 13-15 ends role.
// R22 - Serial defaults 9600 8N1, address 1 within 1 to 247.
// R23 - Interval, group and no-sync timers derive from clock, reload on change; the no-sync count is not restarted when noSyncIvl changes.
// R24 - Slave declares master missing after group interval plus margin, then delays.
`timescale 1ns/10ps
module mas_activation_sync #(
   parameter int POWERUP_CYC = int'(mas_pkg::POWERUP_CYC),
   parameter int MEAS_CYC    = int'(mas_pkg::MEAS_CYC),
   parameter int FLASH_CYC   = int'(mas_pkg::FLASH_CYC),
   parameter int MARGIN_CYC  = int'(mas_pkg::MEAS_CYC),
   parameter int DIST_W      = 16
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Avalon-MM slave
   input  wire logic [5:0]        address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic [31:0]            readdata,
   output logic                   waitrequest,
   // Ranging engine
   output logic                   measStart,
   input  wire logic              measDone,
   input  wire logic [DIST_W-1:0] measDist,
   // Serial framer
   input  wire logic              distPoll,
   output logic                   pollReply,
   output logic [DIST_W-1:0]      replyDist,
   input  wire logic              syncCmdIn,
   output logic                   syncCmdOut,
   output logic                   modbusEnable,
   input  wire logic              teachSyncOff,
   // Outputs and indicators
   output logic                   outUpdate,
   output logic                   outPowerUp,
   output logic                   outNoSync,
   output logic                   ledRed,
   output logic                   ledGreen
);

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   mas_pkg::mas_mode_t              mode;
   logic [2:0]                      phaseCount;
   logic [2:0]                      slavePhase;
   logic                            masterOn;
   logic [mas_pkg::CNT_W-1:0]       measIvl;
   logic [mas_pkg::CNT_W-1:0]       noSyncIvl;
   logic [7:0]                      busAddr;
   logic [2:0]                      baudSel;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic                            ready;
   logic                            busy;
   logic                            pending;
   logic                            firstDone;
   logic                            missing;
   logic                            noSync;
   logic                            offsetRun;
   logic                            flashTick;
   logic                            flashPhase;
   logic [DIST_W-1:0]               storedDist;
   logic [31:0]                     pwrCount, resultCount, missCount, nsCount;
   logic [31:0]                     offsetCount, flashCount;
   logic                            syncMeta, syncSample, syncPrev;
   logic                            pollMeta, pollSample, pollPrev;
   logic                            teachMeta, teachSample;

   logic                            syncEdge;
   logic                            pollEdge;
   logic                            masterActive;
   logic                            slaveOk;
   logic                            ivlTick;
   logic [mas_pkg::CNT_W-1:0]       groupIvl;
   logic [mas_pkg::CNT_W-1:0]       activeIvl;
   logic                            startReq;
   logic [31:0]                     missLimit;
   logic                            wrAccess;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         {syncMeta, syncSample, syncPrev} <= 3'h0;
         {pollMeta, pollSample, pollPrev} <= 3'h0;
         {teachMeta, teachSample} <= 2'h0;
      end
      else
      begin
         {syncMeta, syncSample, syncPrev} <= {syncCmdIn, syncMeta, syncSample};
         {pollMeta, pollSample, pollPrev} <= {distPoll, pollMeta, pollSample};
         {teachMeta, teachSample} <= {teachSyncOff, teachMeta};
      end
   end

   assign syncEdge = syncSample && !syncPrev;
   assign pollEdge = pollSample && !pollPrev;

   assign masterActive = (mode == mas_pkg::MAS_MASTER) && masterOn;
   // Misconfigured slave phase leaves the slave idle
   assign slaveOk = slavePhase >= mas_pkg::PHASE_MIN && slavePhase <= mas_pkg::PHASE_MAX; // R14
   assign groupIvl = mas_pkg::CNT_W'(phaseCount) * measIvl; // R9
   assign activeIvl = (mode == mas_pkg::MAS_MASTER) ? groupIvl : measIvl;
   assign missLimit = 32'(groupIvl) + 32'(MARGIN_CYC); // R24

   // ----------------------------------------------------------------
   // Interval timer
   // ----------------------------------------------------------------
   mas_interval_timer #(
      .CNT_W  (mas_pkg::CNT_W)
   ) u_ivl (
      .clk     (clk),
      .sys_rst (sys_rst),
      .enable  (ready && (mode == mas_pkg::MAS_CONT || masterActive)),
      .restart (1'b0),
      .period  (activeIvl),
      .tick    (ivlTick)
   );

   // ----------------------------------------------------------------
   // Avalon-MM register port
   // ----------------------------------------------------------------
   // One wait state per access: waitrequest drops the cycle after request
   assign wrAccess = write && waitrequest == 1'b0;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         waitrequest <= 1'b1;
      else if ((read || write) && waitrequest)
         waitrequest <= 1'b0;
      else
         waitrequest <= 1'b1;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mode       <= mas_pkg::MAS_CONT; // R3
         phaseCount <= mas_pkg::PHASE_DEF; // R12
         slavePhase <= mas_pkg::PHASE_MIN;
         masterOn   <= 1'b1;
         measIvl    <= mas_pkg::CNT_W'(mas_pkg::MEAS_CYC);
         noSyncIvl  <= mas_pkg::CNT_W'(mas_pkg::MEAS_CYC);
         busAddr    <= mas_pkg::ADDR_DEF; // R22
         baudSel    <= mas_pkg::BAUD_DEF; // R22
      end
      else
      begin
         // Teach selection 13 to 15 drops the master role
         if (teachSample) // R21
            masterOn <= 1'b0;
         if (wrAccess && byteenable[0] && address == mas_pkg::REG_CTRL)
         begin
            mode <= mas_pkg::mas_mode_t'(writedata[mas_pkg::CTRL_MODE_LSB +: 2]); // R3
         end
         if (wrAccess && byteenable[1] && address == mas_pkg::REG_CTRL)
         begin
            if (writedata[mas_pkg::CTRL_PHASE_LSB +: 3] >= mas_pkg::PHASE_MIN &&
                writedata[mas_pkg::CTRL_PHASE_LSB +: 3] <= mas_pkg::PHASE_MAX)
               phaseCount <= writedata[mas_pkg::CTRL_PHASE_LSB +: 3]; // R12
            slavePhase <= writedata[mas_pkg::CTRL_SLPH_LSB +: 3];
            masterOn   <= writedata[mas_pkg::CTRL_MSYNC_BIT]; // R21
         end
         if (wrAccess && address == mas_pkg::REG_MEASIVL && writedata != '0)
            measIvl <= writedata; // R23
         if (wrAccess && address == mas_pkg::REG_NOSYNC && writedata != '0)
            noSyncIvl <= writedata; // R23
         if (wrAccess && byteenable[0] && address == mas_pkg::REG_SERIAL &&
             writedata[mas_pkg::SER_ADDR_LSB +: 8] != 8'h00 &&
             writedata[mas_pkg::SER_ADDR_LSB +: 8] <= mas_pkg::ADDR_MAX)
            busAddr <= writedata[mas_pkg::SER_ADDR_LSB +: 8]; // R22
         if (wrAccess && byteenable[1] && address == mas_pkg::REG_SERIAL)
            baudSel <= writedata[mas_pkg::SER_BAUD_LSB +: 3];
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         readdata <= '0;
      else if (read && waitrequest)
      begin
         case (address)
            mas_pkg::REG_CTRL:
               readdata <= {19'h0_0000, masterOn, 1'b0, slavePhase, 1'b0, phaseCount,
                            2'h0, 2'(mode)};
            mas_pkg::REG_MEASIVL: readdata <= measIvl;
            mas_pkg::REG_NOSYNC:  readdata <= noSyncIvl;
            mas_pkg::REG_SERIAL:  readdata <= {21'h00_0000, baudSel, busAddr};
            mas_pkg::REG_STATUS:
               readdata <= {25'h000_0000, !masterActive, pending, ready, noSync,
                            missing, firstDone, busy};
            mas_pkg::REG_DIST:    readdata <= 32'(storedDist);
            mas_pkg::REG_RESULT:  readdata <= resultCount;
            default:              readdata <= mas_pkg::UNMAPPED_RD;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Power-up sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pwrCount <= '0;
         ready    <= 1'b0;
      end
      // Ready well inside the power-up bound; count is a parameter for sim
      else if (!ready) // R1
      begin
         if (pwrCount >= 32'(POWERUP_CYC / 2))
            ready <= 1'b1;
         else
            pwrCount <= pwrCount + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // Slave sync supervision and phase offset
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         missCount <= '0;
         missing   <= 1'b0;
         nsCount   <= '0;
         noSync    <= 1'b0;
      end
      else if (mode != mas_pkg::MAS_SLAVE || !ready || syncEdge) // R16
      begin
         missCount <= '0;
         missing   <= 1'b0;
         nsCount   <= '0;
         noSync    <= 1'b0;
      end
      else if (!missing)
      begin
         if (missCount >= missLimit) // R24
            missing <= 1'b1;
         else
            missCount <= missCount + 32'h0000_0001;
      end
      else if (!noSync)
      begin
         if (nsCount >= 32'(noSyncIvl)) // R15
            noSync <= 1'b1;
         else
            nsCount <= nsCount + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         offsetRun   <= 1'b0;
         offsetCount <= '0;
      end
      else if (mode != mas_pkg::MAS_SLAVE || !slaveOk || slavePhase > phaseCount)
      begin
         offsetRun   <= 1'b0;
         offsetCount <= '0;
      end
      // Phase 1 starts on the command itself, phase n waits n-1 intervals
      else if (syncEdge) // R11 R13
      begin
         offsetRun   <= 1'b1;
         offsetCount <= 32'(slavePhase - mas_pkg::PHASE_MIN) * 32'(measIvl);
      end
      else if (offsetRun && offsetCount != '0)
         offsetCount <= offsetCount - 32'h0000_0001;
      else
         offsetRun <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Measurement start control
   // ----------------------------------------------------------------
   always_comb
   begin
      startReq = 1'b0;
      case (mode)
         mas_pkg::MAS_CONT:   startReq = ivlTick; // R4
         mas_pkg::MAS_POLL:   startReq = pollEdge || pending; // R6
         mas_pkg::MAS_MASTER: startReq = ivlTick; // R9 R18
         mas_pkg::MAS_SLAVE:  startReq = offsetRun && offsetCount == '0 && !missing; // R11 R15
         default:             startReq = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy      <= 1'b0;
         pending   <= 1'b0;
         measStart <= 1'b0;
      end
      else
      begin
         measStart <= 1'b0;
         // Poll during a process is queued, never dropped
         if (mode == mas_pkg::MAS_POLL && pollEdge && (busy || measStart)) // R8
            pending <= 1'b1;
         if (measDone)
            busy <= 1'b0;
         if (ready && startReq && !busy && !measStart && !measDone)
         begin
            busy      <= 1'b1;
            measStart <= 1'b1;
            if (mode == mas_pkg::MAS_POLL && !pollEdge)
               pending <= 1'b0; // R8
         end
         if (mode != mas_pkg::MAS_POLL)
            pending <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Result store and output update
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         storedDist  <= '0;
         firstDone   <= 1'b0;
         resultCount <= '0;
         outUpdate   <= 1'b0;
         outPowerUp  <= 1'b1;
         outNoSync   <= 1'b0;
      end
      else
      begin
         outUpdate <= 1'b0;
         outNoSync <= noSync; // R15 R16
         if (measDone && busy && !(mode == mas_pkg::MAS_SLAVE && missing))
         begin
            storedDist  <= measDist; // R4 R6
            firstDone   <= 1'b1;
            resultCount <= resultCount + 32'h0000_0001;
            outUpdate   <= 1'b1; // R18
            outPowerUp  <= 1'b0; // R2
         end
      end
   end

   // ----------------------------------------------------------------
   // Serial side: poll replies, sync commands, bus ownership
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pollReply    <= 1'b0;
         replyDist    <= '0;
         syncCmdOut   <= 1'b0;
         modbusEnable <= 1'b0;
      end
      else
      begin
         // Sync traffic and Modbus are exclusive on the shared pair
         modbusEnable <= ready && !masterActive; // R17 R20 R21
         syncCmdOut   <= masterActive && ivlTick && ready; // R10 R17
         pollReply    <= 1'b0;
         // Reply uses the value stored before this poll's own process
         if (pollEdge && ready && !masterActive && mode != mas_pkg::MAS_SLAVE &&
             firstDone) // R5 R7 R10
         begin
            pollReply <= 1'b1;
            replyDist <= storedDist;
         end
      end
   end

   // ----------------------------------------------------------------
   // Target indicator
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         flashCount <= '0;
         flashTick  <= 1'b0;
         flashPhase <= 1'b0;
         ledRed     <= 1'b1;
         ledGreen   <= 1'b0;
      end
      else
      begin
         flashTick <= 1'b0;
         if (flashCount >= 32'(FLASH_CYC - 1))
         begin
            flashCount <= '0;
            flashTick  <= 1'b1;
         end
         else
            flashCount <= flashCount + 32'h0000_0001;
         if (flashTick)
            flashPhase <= !flashPhase;
         if (missing) // R15
         begin
            ledRed   <= !flashPhase;
            ledGreen <= flashPhase;
         end
         else if (!firstDone) // R1 R2
         begin
            ledRed   <= 1'b1;
            ledGreen <= 1'b0;
         end
         else
         begin
            ledRed   <= 1'b0;
            ledGreen <= 1'b1;
         end
      end
   end

endmodule : mas_activation_sync

/* File: rtl/mas_pkg.sv */
/*
 Constants shared by the measurement activation and group sync block:
 register map, field positions, reset values, mode and timing figures.
 Assumes a 20 MHz system clock and a 32-bit Avalon-MM register port.
*/
package mas_pkg;

   // ----------------------------------------------------------------
   // Clock and time
   // ----------------------------------------------------------------
   localparam longint CLK_HZ          = 20_000_000;
   localparam longint POWERUP_MS      = 1200;
   localparam longint POWERUP_CYC     = (POWERUP_MS * CLK_HZ) / 1000;
   localparam longint MEAS_MS         = 50;
   localparam longint MEAS_CYC        = (MEAS_MS * CLK_HZ) / 1000;
   localparam longint FLASH_MS        = 250;
   localparam longint FLASH_CYC       = (FLASH_MS * CLK_HZ) / 1000;
   localparam int     CNT_W           = 32;

   // ----------------------------------------------------------------
   // Modes and defaults
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MAS_CONT,
      MAS_POLL,
      MAS_MASTER,
      MAS_SLAVE
   } mas_mode_t;

   localparam logic [2:0] PHASE_DEF   = 3'h2;
   localparam logic [2:0] PHASE_MIN   = 3'h1;
   localparam logic [2:0] PHASE_MAX   = 3'h5;
   localparam logic [7:0] ADDR_DEF    = 8'h01;
   localparam logic [7:0] ADDR_MAX    = 8'hF7;
   localparam logic [2:0] BAUD_DEF    = 3'h0;
   localparam logic [3:0] TEACH_SYNC_LO = 4'hD;
   localparam logic [3:0] TEACH_SYNC_HI = 4'hF;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [5:0] REG_CTRL    = 6'h00;
   localparam logic [5:0] REG_MEASIVL = 6'h04;
   localparam logic [5:0] REG_NOSYNC  = 6'h08;
   localparam logic [5:0] REG_SERIAL  = 6'h0C;
   localparam logic [5:0] REG_STATUS  = 6'h10;
   localparam logic [5:0] REG_DIST    = 6'h14;
   localparam logic [5:0] REG_RESULT  = 6'h18;

   // CTRL fields
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_PHASE_LSB = 4;
   localparam int CTRL_SLPH_LSB  = 8;
   localparam int CTRL_MSYNC_BIT = 12;

   // SERIAL fields
   localparam int SER_ADDR_LSB = 0;
   localparam int SER_BAUD_LSB = 8;

   // STATUS fields
   localparam int ST_BUSY_BIT    = 0;
   localparam int ST_VALID_BIT   = 1;
   localparam int ST_NOSYNC_BIT  = 2;
   localparam int ST_NOOUT_BIT   = 3;
   localparam int ST_READY_BIT   = 4;
   localparam int ST_PEND_BIT    = 5;
   localparam int ST_BUSOWN_BIT  = 6;

   localparam logic [31:0] UNMAPPED_RD = 32'hDEAD_BEEF;

endpackage : mas_pkg

/* File: rtl/mas_interval_timer.sv */
/*
 Down-counting interval timer giving a one-cycle tick each period.
 Reloads at once when the period value changes, or on restart.
 Assumes period is at least one and comes from the same clock.
*/
`timescale 1ns/10ps
module mas_interval_timer #(
   parameter int CNT_W = 32
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             enable,
   input  wire logic             restart,
   input  wire logic [CNT_W-1:0] period,
   output logic                  tick
);

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] lastPeriod;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         count      <= '0;
         lastPeriod <= '0;
         tick       <= 1'b0;
      end
      else
      begin
         lastPeriod <= period;
         tick       <= 1'b0;
         // Changed period restarts counting so no stale long wait remains
         if (!enable || restart || period != lastPeriod) // R23
            count <= period - CNT_W'(1);
         else if (count == '0)
         begin
            tick  <= 1'b1;
            count <= period - CNT_W'(1);
         end
         else
            count <= count - CNT_W'(1);
      end
   end

endmodule : mas_interval_timer

/* File: dv/mas_checker.sv */
/* Port checker for the activation block.
   Assumes binding onto mas_activation_sync. */
`timescale 1ns/10ps
module mas_checker (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        read,
   input wire logic        write,
   input wire logic        waitrequest,
   input wire logic        measStart,
   input wire logic        measDone,
   input wire logic        outUpdate,
   input wire logic        outPowerUp,
   input wire logic        pollReply,
   input wire logic [15:0] replyDist,
   input wire logic        syncCmdOut,
   input wire logic        modbusEnable
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_req;
      (read || write) && waitrequest;
   endsequence
   a_bus_answer: assert property (s_req |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle");
   a_start_pulse: assert property (measStart |=> !measStart)
      else $error("start pulse too long");
   a_update_cause: assert property (outUpdate |-> $past(measDone))
      else $error("update without result");
   a_first_result: assert property ($fell(outPowerUp) |-> $past(measDone))
      else $error("power-up state left early");
   a_no_early: assert property (outPowerUp |-> !pollReply)
      else $error("reply before first result");
   a_sync_alone: assert property (syncCmdOut |-> !modbusEnable)
      else $error("sync while serial open");
   a_reply_hold: assert property ($changed(replyDist) |-> pollReply)
      else $error("reply distance moved");
   a_master_mute: assert property (!modbusEnable |-> !pollReply)
      else $error("reply while serial closed");
endmodule : mas_checker
bind mas_activation_sync mas_checker uChk (.clk, .sys_rst, .read, .write, .waitrequest,
   .measStart, .measDone, .outUpdate, .outPowerUp, .pollReply, .replyDist, .syncCmdOut,
   .modbusEnable);

/* File: dv/mas_ranging_model.sv */
/* Ranging engine model: one result LAT cycles after each start.
   Assumes the block's clock. */
`timescale 1ns/10ps
module mas_ranging_model #(
   parameter int LAT = 30
) (
   input  wire logic        clk,
   input  wire logic        measStart,
   output logic             measDone = 1'b0,
   output logic [15:0]      measDist = 16'h0000
);
   int          cnt = 0;
   logic [15:0] distSeq = 16'h0100;
   always @(posedge clk)
   begin
      measDone <= 1'b0;
      measDist <= ~measDist; // Stale data never looks valid
      cnt <= measStart ? LAT : (cnt > 0 ? cnt - 1 : 0);
      if (cnt == 1 && !measStart)
      begin
         measDone <= 1'b1;
         measDist <= distSeq;
         distSeq <= distSeq + 16'h0001;
      end
   end
endmodule : mas_ranging_model

/* File: dv/measurement_activation_sync_tb_top.sv */
/* Bench: Avalon-MM accesses, polls and sync pulses.
   Assumes checker and ranging model compiled first. */
`timescale 1ns/10ps
module measurement_activation_sync_tb_top;
   localparam int          IVL = 40;
   localparam logic [31:0] ONE = 32'h0000_0001;
   logic        clk = 1'b0, sys_rst = 1'b1, read = 1'b0, write = 1'b0;
   logic        distPoll = 1'b0, syncCmdIn = 1'b0, teachSyncOff = 1'b0;
   logic [5:0]  address = 6'h00;
   logic [31:0] writedata = '0, readdata, rd;
   logic        waitrequest, measStart, measDone, pollReply, syncCmdOut, modbusEnable;
   logic        outUpdate, outPowerUp, outNoSync, ledRed, ledGreen;
   logic [15:0] measDist, replyDist, lastDist = 16'h0000;
   int          fail_count = 0, n_compared = 0, cyc = 0, nStart = 0, nRep = 0, t, n;
   mas_activation_sync #(.POWERUP_CYC(200), .MEAS_CYC(100), .FLASH_CYC(10),
      .MARGIN_CYC(20)) uut (.clk, .sys_rst, .address, .read, .write, .writedata,
      .byteenable(4'hF), .readdata, .waitrequest, .measStart, .measDone, .measDist,
      .distPoll, .pollReply, .replyDist, .syncCmdIn, .syncCmdOut, .modbusEnable,
      .teachSyncOff, .outUpdate, .outPowerUp, .outNoSync, .ledRed, .ledGreen);
   mas_ranging_model uRange (.clk, .measStart, .measDone, .measDist);
   always #25 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      nStart <= nStart + int'(measStart);
      nRep <= nRep + int'(pollReply);
      if (measDone)
         lastDist <= measDist;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      {read, write, address, writedata} <= {!w, w, a, d};
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      {read, write} <= 2'b00;
      @(posedge clk);
   endtask : bus
   task automatic pulse(input logic s); // Held three cycles for the input synchroniser
      if (s) syncCmdIn <= 1'b1; else distPoll <= 1'b1;
      repeat (3) @(posedge clk);
      {distPoll, syncCmdIn} <= 2'b00;
   endtask : pulse
   task automatic complete_run;
      if (fail_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      chk(32'({ledRed, outPowerUp}), 32'h0000_0003);
      bus(1'b0, mas_pkg::REG_CTRL, '0);
      chk(rd & 32'h0000_0073, 32'h0000_0020);
      bus(1'b0, mas_pkg::REG_SERIAL, '0);
      chk(rd & 32'h0000_07FF, ONE);
      bus(1'b0, 6'h3C, '0);
      chk(rd, mas_pkg::UNMAPPED_RD);
      bus(1'b1, mas_pkg::REG_MEASIVL, IVL);
      bus(1'b1, mas_pkg::REG_NOSYNC, 32'h0000_0032);
      do bus(1'b0, mas_pkg::REG_STATUS, '0); while (rd[mas_pkg::ST_READY_BIT] !== 1'b1);
      @(posedge clk iff measStart);
      t = cyc;
      @(posedge clk iff measStart);
      chk(cyc - t, IVL);
      chk(32'({outPowerUp, ledRed, ledGreen}), ONE);
      bus(1'b0, mas_pkg::REG_DIST, '0);
      chk(rd, 32'(lastDist));
      pulse(1'b0);
      @(posedge clk iff pollReply);
      chk(32'(replyDist), 32'(lastDist));
      bus(1'b1, mas_pkg::REG_CTRL, 32'h0000_1021);
      repeat (IVL) @(posedge clk);
      n = nStart;
      pulse(1'b0);
      @(posedge clk iff pollReply);
      chk(32'(replyDist), 32'(lastDist));
      pulse(1'b0);
      repeat (100) @(posedge clk);
      chk(nStart - n, 2);
      bus(1'b1, mas_pkg::REG_CTRL, 32'h0000_1032);
      @(posedge clk iff syncCmdOut);
      t = cyc;
      @(posedge clk iff syncCmdOut);
      chk(cyc - t, 3 * IVL);
      n = nRep;
      pulse(1'b0);
      repeat (10) @(posedge clk);
      chk(nRep - n, '0);
      chk(32'(modbusEnable), '0);
      teachSyncOff <= 1'b1;
      repeat (8) @(posedge clk);
      chk(32'(modbusEnable), ONE);
      teachSyncOff <= 1'b0;
      bus(1'b1, mas_pkg::REG_CTRL, 32'h0000_1223);
      t = cyc;
      pulse(1'b1);
      @(posedge clk iff measStart);
      chk(32'((cyc - t) inside {[IVL:IVL + 8]}), ONE);
      @(posedge clk iff outNoSync);
      chk(32'((cyc - t) inside {[150:162]}), ONE);
      pulse(1'b1);
      repeat (6) @(posedge clk);
      chk(32'(outNoSync), '0);
      complete_run();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      complete_run();
   end
endmodule : measurement_activation_sync_tb_top
